/* File: include/dac_defines.svh */
`ifndef DAC_DEFINES_SVH
`define DAC_DEFINES_SVH
`define DAC_OFF_CONTROL 12'h000
`define DAC_OFF_LOW 12'h004
`define DAC_OFF_HIGH 12'h008
`define DAC_OFF_STATUS 12'h00C
`define DAC_CTL_AUTO 7
`define DAC_CTL_TSEL_HI 6
`define DAC_CTL_TSEL_LO 4
`define DAC_CTL_LEFT 2
`define DAC_CTL_OUTEN 1
`define DAC_CTL_EN 0
`define DAC_CTL_MASK 8'hF7
`define DAC_RESET_BYTE 8'h00
`define DAC_RESET_VALUE 10'h000
`define DAC_MIN_ADDR_WIDTH 4
`endif

/* File: include/dac_pkg.sv */
package dac_pkg;
  typedef logic [9:0] dac_value_t;
  typedef struct packed {
    logic [7:0] control;
    logic [7:0] value_low;
    logic [7:0] value_high;
    logic low_pending;
    logic high_written;
    logic [7:0] trig_prev;
    logic [9:0] shadow;
    logic [31:0] prdata;
  } dac_state_s;
endpackage : dac_pkg

/* File: logic/dac_shadow.sv */
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "dac_defines.svh"
// Notes on behaviour
// - Low write alone never changes output.
// - Converted value comes from hidden shadow.
// - Manual mode: high write copies both bytes.
// - Auto mode: trigger loads after low-high pair.
// - High-only writes: every trigger updates.
// - Left align: high is bits 9..2.
// - Auto enable picks trigger edge over write.
// - Three-bit select over eight trigger flags.
// - Alignment change shows at next shadow load.
// - Enable drives converter from shadow value.
module dac_shadow
  import dac_pkg::*;
#(
  parameter int ADDR_WIDTH = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] trigger_flags,
  output logic [9:0] converter_value,
  output logic converter_enable,
  output logic converter_output_enable
);

  // Status sits at the top offset, so narrower addresses cannot reach it
  if (ADDR_WIDTH < `DAC_MIN_ADDR_WIDTH) begin : g_addr_check
    $error("ADDR_WIDTH too small for register map");
  end

  dac_state_s st;
  dac_state_s next_st;

  function automatic dac_value_t dac_assemble(input logic left, input logic [7:0] hi,
                                              input logic [7:0] lo);
    if (left) return {hi, lo[7:6]};
    else return {hi[1:0], lo};
  endfunction : dac_assemble

  function automatic logic dac_at(input logic [ADDR_WIDTH-1:0] a, input logic [11:0] off);
    return a == ADDR_WIDTH'(off);
  endfunction : dac_at

  logic setup_access;
  logic wr_access;
  logic addr_hit;
  logic wr_low;
  logic wr_high;
  logic wr_ctrl;
  logic trig_now;
  logic trig_edge;
  logic auto_mode;

  assign setup_access = psel && penable;
  // Every register lives in byte lane 0; the other lanes are ignored
  assign wr_access = setup_access && pwrite && pstrb[0];
  assign addr_hit = dac_at(paddr, `DAC_OFF_CONTROL) ||
                    dac_at(paddr, `DAC_OFF_LOW) ||
                    dac_at(paddr, `DAC_OFF_HIGH) ||
                    dac_at(paddr, `DAC_OFF_STATUS);
  assign wr_low = wr_access && dac_at(paddr, `DAC_OFF_LOW);
  assign wr_high = wr_access && dac_at(paddr, `DAC_OFF_HIGH);
  assign wr_ctrl = wr_access && dac_at(paddr, `DAC_OFF_CONTROL);
  assign auto_mode = st.control[`DAC_CTL_AUTO];
  // Flag level is tracked always, so a select change cannot fake an edge
  assign trig_now = trigger_flags[st.control[`DAC_CTL_TSEL_HI:`DAC_CTL_TSEL_LO]];
  assign trig_edge = trig_now &&
                     !st.trig_prev[st.control[`DAC_CTL_TSEL_HI:`DAC_CTL_TSEL_LO]];

  always_comb begin
    next_st = st;
    next_st.trig_prev = trigger_flags;
    if (wr_ctrl) begin
      next_st.control = pwdata[7:0] & `DAC_CTL_MASK;
    end
    if (wr_low) begin
      next_st.value_low = pwdata[7:0];
      next_st.low_pending = 1'b1;
      next_st.high_written = 1'b0;
    end
    if (wr_high) begin
      next_st.value_high = pwdata[7:0];
      next_st.low_pending = 1'b0;
      next_st.high_written = 1'b1;
      if (!auto_mode) begin
        // Uses the current align bit, so an align change lands here
        next_st.shadow = dac_assemble(st.control[`DAC_CTL_LEFT], pwdata[7:0],
                                      st.value_low);
      end
    end
    // Pair must be complete; a low write alone blocks the refresh
    if (auto_mode && trig_edge && !st.low_pending && st.high_written && !wr_high) begin
      next_st.shadow = dac_assemble(st.control[`DAC_CTL_LEFT], st.value_high,
                                    st.value_low);
    end
    // Captured in setup, so read data is a flop by the access edge
    next_st.prdata = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        ADDR_WIDTH'(`DAC_OFF_CONTROL): next_st.prdata = {24'h000000, st.control};
        ADDR_WIDTH'(`DAC_OFF_LOW): next_st.prdata = {24'h000000, st.value_low};
        ADDR_WIDTH'(`DAC_OFF_HIGH): next_st.prdata = {24'h000000, st.value_high};
        ADDR_WIDTH'(`DAC_OFF_STATUS): next_st.prdata = {30'h0000_0000, st.high_written,
                                                        st.low_pending};
        default: next_st.prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.control <= `DAC_RESET_BYTE;
      st.value_low <= `DAC_RESET_BYTE;
      st.value_high <= `DAC_RESET_BYTE;
      st.low_pending <= 1'b0;
      st.high_written <= 1'b0;
      st.trig_prev <= 8'h00;
      st.shadow <= `DAC_RESET_VALUE;
      st.prdata <= 32'h0000_0000;
    end else begin
      st <= next_st;
    end
  end

  assign pready = 1'b1;
  assign pslverr = setup_access && !addr_hit;
  assign prdata = st.prdata;
  // Shadow feeds the converter; data registers never reach it directly
  assign converter_value = st.shadow;
  assign converter_enable = st.control[`DAC_CTL_EN];
  assign converter_output_enable = st.control[`DAC_CTL_OUTEN];

  // Only two paths reach the shadow: manual high write, auto trigger edge
  a_low_holds_out: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_low && !(auto_mode && trig_edge)) |=> $stable(converter_value))
    else $error("output moved after low write without high write");

  a_low_marks: assert property (@(posedge pclk) disable iff (!presetn)
    wr_low |=> (st.low_pending && !st.high_written))
    else $error("low write did not mark pair pending");

  a_high_closes: assert property (@(posedge pclk) disable iff (!presetn)
    wr_high |=> (!st.low_pending && st.high_written))
    else $error("high write did not close the pair");

  a_manual_copy: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_high && !auto_mode) |=>
    converter_value == dac_assemble($past(st.control[`DAC_CTL_LEFT]), $past(pwdata[7:0]),
                                    $past(st.value_low)))
    else $error("manual high write did not copy both bytes");

  a_auto_trigger: assert property (@(posedge pclk) disable iff (!presetn)
    (auto_mode && trig_edge && !st.low_pending && st.high_written && !wr_high) |=>
    converter_value == $past(dac_assemble(st.control[`DAC_CTL_LEFT], st.value_high,
                                          st.value_low)))
    else $error("trigger edge did not refresh shadow");

  a_auto_no_write: assert property (@(posedge pclk) disable iff (!presetn)
    (auto_mode && !trig_edge) |=> $stable(converter_value))
    else $error("auto mode updated without trigger edge");

  // A flag held high is one event, not one per cycle
  a_edge_level: assert property (@(posedge pclk) disable iff (!presetn)
    (auto_mode && trig_now && !trig_edge) |=> $stable(converter_value))
    else $error("held trigger level refreshed the shadow again");

  a_eight_bit: assert property (@(posedge pclk) disable iff (!presetn)
    (auto_mode && trig_edge && !st.low_pending && st.high_written && !wr_high &&
     st.control[`DAC_CTL_LEFT]) |=>
    converter_value[9:2] == $past(st.value_high))
    else $error("trigger did not reload high byte");

  a_pending_block: assert property (@(posedge pclk) disable iff (!presetn)
    (st.low_pending && !wr_high) |=> $stable(converter_value))
    else $error("update while low byte pending");

  a_shadow_hidden: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_access && !wr_high && !(auto_mode && trig_edge)) |=> $stable(converter_value))
    else $error("register write other than high reached the shadow");

  a_align_late: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ctrl && !(auto_mode && trig_edge)) |=> $stable(converter_value))
    else $error("alignment change moved output before high write");

  // Refused writes must leave every software register alone
  a_refused_write: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_access && pwrite && !addr_hit) |=>
    ($stable(st.control) && $stable(st.value_low) && $stable(st.value_high)))
    else $error("write to unmapped address changed a register");

  a_left_align: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_high && !auto_mode && st.control[`DAC_CTL_LEFT]) |=>
    converter_value[9:2] == $past(pwdata[7:0]))
    else $error("left alignment wrong");

  a_right_align: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_high && !auto_mode && !st.control[`DAC_CTL_LEFT]) |=>
    converter_value == {$past(pwdata[1:0]), $past(st.value_low)})
    else $error("right alignment wrong");

  a_enable_out: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl |=>
    converter_enable == $past(pwdata[`DAC_CTL_EN]))
    else $error("enable not following control write");

  // Scenarios worth seeing hit at least once
  c_manual: cover property (@(posedge pclk) disable iff (!presetn) wr_low ##[1:8] wr_high);
  c_auto: cover property (@(posedge pclk) disable iff (!presetn) auto_mode && trig_edge);
  c_left: cover property (@(posedge pclk) disable iff (!presetn)
    wr_high && st.control[`DAC_CTL_LEFT]);
  c_right: cover property (@(posedge pclk) disable iff (!presetn)
    wr_high && !auto_mode && !st.control[`DAC_CTL_LEFT]);
  c_pending_block: cover property (@(posedge pclk) disable iff (!presetn)
    auto_mode && trig_edge && st.low_pending);

endmodule : dac_shadow

/* File: verification/test_dac_shadow.sv */
`timescale 1ns/1ps
module test_dac_shadow;
  import dac_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic [7:0] trigger_flags = '0;
  logic pready, pslverr, er, converter_enable, converter_output_enable;
  dac_value_t converter_value, ex;
  int n_errors = 0, n_tests = 0, cyc = 0;
  dac_shadow dac_shadow_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trigger_flags(trigger_flags),
    .converter_value(converter_value), .converter_enable(converter_enable),
    .converter_output_enable(converter_output_enable));
  initial begin
    forever #4 pclk = ~pclk;
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Two idle edges after release let registered outputs settle before checks
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : apb
  task automatic pulse(input int s);
    @(posedge pclk);
    trigger_flags <= 8'h01 << s;
    repeat (2) @(posedge pclk);
    trigger_flags <= 8'h00;
    repeat (3) @(posedge pclk);
  endtask : pulse
  task automatic t_reset();
    apb(1'b0, 12'h004, 32'h0);
    chk("low reset", rd, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk("high reset", rd, 32'h0);
    chk("value reset", converter_value, 32'h0);
  endtask : t_reset
  task automatic t_manual();
    apb(1'b1, 12'h000, 32'h03);
    chk("enables", {converter_output_enable, converter_enable}, 32'h3);
    apb(1'b1, 12'h004, 32'hAB);
    chk("low only", converter_value, 32'h0);
    apb(1'b1, 12'h008, 32'h03);
    chk("right", converter_value, 32'h3AB);
    apb(1'b0, 12'h004, 32'h0);
    chk("low read", rd, 32'hAB);
    apb(1'b1, 12'h000, 32'h07);
    chk("align held", converter_value, 32'h3AB);
    apb(1'b1, 12'h008, 32'h80);
    chk("left", converter_value, 32'h202);
  endtask : t_manual
  task automatic t_unmapped();
    apb(1'b1, 12'h010, 32'hFF);
    chk("slverr", er, 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped read", rd, 32'h0);
    pstrb <= 4'h0;
    apb(1'b1, 12'h004, 32'h55);
    pstrb <= 4'hF;
    apb(1'b0, 12'h004, 32'h0);
    chk("strobe off", rd, 32'hAB);
    chk("mapped slverr", er, 32'h0);
  endtask : t_unmapped
  // Each source in turn; a neighbour's edge must not load the shadow
  task automatic t_auto();
    ex = 10'h202;
    for (int s = 0; s < 8; s++) begin
      apb(1'b1, 12'h000, 32'h87 | (s << 4));
      apb(1'b1, 12'h008, 32'h10 + s);
      chk("auto held", converter_value, ex);
      pulse((s + 1) % 8);
      chk("other source", converter_value, ex);
      pulse(s);
      ex = {8'h10 + s[7:0], 2'b10};
      chk("auto load", converter_value, ex);
    end
    apb(1'b1, 12'h004, 32'h40);
    pulse(7);
    chk("pending", converter_value, ex);
    apb(1'b0, 12'h00C, 32'h0);
    chk("status pending", rd, 32'h1);
    apb(1'b1, 12'h008, 32'hC3);
    apb(1'b0, 12'h00C, 32'h0);
    chk("status paired", rd, 32'h2);
    pulse(7);
    chk("pair", converter_value, 32'h30D);
  endtask : t_auto
  task automatic final_report();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      final_report();
    end
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_manual();
    t_unmapped();
    t_auto();
    final_report();
  end
endmodule : test_dac_shadow
